/* File: rtl/pmoc_top.v */
`include "pmoc_map.vh"
`default_nettype none

module pmoc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [3:0]  dedicated_in,
    input  wire        sync_clock_left_half,
    input  wire        sync_clock_right_half,
    input  wire [15:0] io_in,
    output reg  [15:0] io_out,
    output reg  [15:0] io_oe,
    output reg         standby
);
    // ***********************************************
    // configuration storage
    // ***********************************************
    reg  [15:0] cell_cfg [0:15];
    // per cell: term_and[c][k] = AND mask low 20 true, high 20 compl, stored as packed 40 bits per term
    reg  [39:0] term_mask [0:159];
    reg         speed_bit;
    reg         secure_bit;
    reg  [15:0] cell_reg;
    reg  [15:0] fb_val;
    reg  [15:0] clk_term_q;
    reg  [19:0] in_prev;
    reg  [2:0]  idle_cnt;
    reg  [1:0]  wake_cnt;
    reg         left_prev;
    reg         right_prev;
    reg  [39:0] array_in;
    reg  [159:0] term_val;
    reg  [15:0] next_cell_reg;
    reg  [15:0] next_sum;
    reg  [15:0] next_oe;
    reg  [15:0] next_clk_term;
    reg         in_bit_a;
    reg         in_bit_b;

    // wake delay, cut to the width of its counter
    localparam [31:0] wake_load = `PMOC_WAKE_CYC;

    wire [19:0] pins_now = {io_in, dedicated_in};
    wire        any_change = (pins_now != in_prev);
    wire        left_rise = sync_clock_left_half & ~left_prev;
    wire        right_rise = sync_clock_right_half & ~right_prev;

    // ***********************************************
    // product-term array
    // ***********************************************
    always @* begin : array_eval
        integer k;
        k = 0;
        array_in[15:0] = fb_val;
        array_in[19:16] = dedicated_in;
        array_in[39:20] = ~{dedicated_in, fb_val};
        for (k = 0; k < 160; k = k + 1) begin
            // all connections open gives true; both polarities kept gives false
            term_val[k] = &(~term_mask[k] | array_in);
        end
    end

    // ***********************************************
    // macrocell next state
    // ***********************************************
    always @* begin : cell_eval
        integer c;
        integer k;
        c = 0;
        k = 0;
        next_cell_reg = cell_reg;
        next_sum = 16'h0000;
        next_oe = 16'h0000;
        next_clk_term = 16'h0000;
        in_bit_a = 1'b0;
        in_bit_b = 1'b0;
        for (c = 0; c < 16; c = c + 1) begin
            in_bit_a = 1'b0;
            in_bit_b = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (cell_cfg[c][`PMOC_F_TYPE_HI]) begin
                    // split mask bit chooses J/S or K/R gate
                    if (cell_cfg[c][`PMOC_F_SPLIT_LO + k]) begin
                        in_bit_a = in_bit_a | term_val[c*10+k];
                    end else begin
                        in_bit_b = in_bit_b | term_val[c*10+k];
                    end
                end else begin
                    in_bit_a = in_bit_a | term_val[c*10+k];
                end
            end
            // the erased invert bit gives the active-low output
            if (cell_cfg[c][`PMOC_F_INV]) begin
                in_bit_a = ~in_bit_a;
                in_bit_b = ~in_bit_b;
            end
            next_sum[c] = in_bit_a;
            next_clk_term[c] = term_val[c*10+9];
            next_oe[c] = cell_cfg[c][`PMOC_F_MODE] ? term_val[c*10+9] : 1'b1;
            if ((cell_cfg[c][`PMOC_F_MODE] && ((c < 8) ? left_rise : right_rise)) ||
                (!cell_cfg[c][`PMOC_F_MODE] && term_val[c*10+9] && !clk_term_q[c])) begin
                case (cell_cfg[c][`PMOC_F_TYPE_HI:`PMOC_F_TYPE_LO])
                    `PMOC_TYPE_D:  next_cell_reg[c] = in_bit_a;
                    `PMOC_TYPE_T:  next_cell_reg[c] = cell_reg[c] ^ in_bit_a;
                    `PMOC_TYPE_JK: next_cell_reg[c] = (in_bit_a & ~cell_reg[c]) |
                                                      (~in_bit_b & cell_reg[c]);
                    default:       next_cell_reg[c] = in_bit_a | (~in_bit_b & cell_reg[c]);
                endcase
            end
            if (term_val[c*10+8]) begin
                next_cell_reg[c] = 1'b0;
            end
        end
    end

    // ***********************************************
    // standby and wake
    // ***********************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            in_prev <= 20'h0_0000;
            idle_cnt <= 3'h0;
            wake_cnt <= 2'h0;
            standby <= 1'b0;
        end else begin
            in_prev <= pins_now;
            if (wake_cnt != 2'h0) begin
                wake_cnt <= wake_cnt - 2'h1;
            end
            if (any_change) begin
                idle_cnt <= 3'h0;
                if (standby) begin
                    standby <= 1'b0;
                    wake_cnt <= wake_load[1:0];
                end
            end else if (!speed_bit) begin
                if (idle_cnt == (`PMOC_STANDBY_CYC - 1)) begin
                    standby <= 1'b1;
                end else begin
                    idle_cnt <= idle_cnt + 3'h1;
                end
            end else begin
                // speed bit on: leave standby at once and stay awake
                idle_cnt <= 3'h0;
                standby <= 1'b0;
            end
        end
    end

    // ***********************************************
    // macrocell registers and pins
    // ***********************************************
    always @(posedge aclk) begin : pin_update
        integer c;
        if (!aresetn) begin
            cell_reg <= 16'h0000;
            clk_term_q <= 16'h0000;
            left_prev <= 1'b0;
            right_prev <= 1'b0;
            fb_val <= 16'h0000;
            io_out <= 16'h0000;
            io_oe <= 16'h0000;
        end else begin
            left_prev <= sync_clock_left_half;
            right_prev <= sync_clock_right_half;
            if (wake_cnt == 2'h0 && !(standby && any_change)) begin
                cell_reg <= next_cell_reg;
                clk_term_q <= next_clk_term;
                for (c = 0; c < 16; c = c + 1) begin
                    case (cell_cfg[c][`PMOC_F_OSEL_HI:`PMOC_F_OSEL_LO])
                        `PMOC_OSEL_REG: begin
                            io_out[c] <= next_cell_reg[c];
                            io_oe[c] <= next_oe[c];
                        end
                        `PMOC_OSEL_COMB: begin
                            io_out[c] <= next_sum[c];
                            io_oe[c] <= next_oe[c];
                        end
                        default: begin
                            io_out[c] <= 1'b0;
                            io_oe[c] <= 1'b0;
                        end
                    endcase
                    case (cell_cfg[c][`PMOC_F_FSEL_HI:`PMOC_F_FSEL_LO])
                        `PMOC_FSEL_REG: fb_val[c] <= next_cell_reg[c];
                        `PMOC_FSEL_PIN: fb_val[c] <= io_in[c];
                        default:        fb_val[c] <= 1'b0;
                    endcase
                end
            end
        end
    end

    // ***********************************************
    // axi4-lite slave
    // ***********************************************
    reg        aw_held;
    reg        w_held;
    reg [31:0] aw_addr;
    reg [31:0] w_data;
    wire [11:0] wa = aw_addr[11:0];
    wire [11:0] ra = s_axi_araddr[11:0];
    wire [3:0]  w_cell = wa[5:2];
    wire [7:0]  w_term = {2'b00, wa[7:2]} - 8'h20;
    wire [7:0]  r_term = {2'b00, ra[7:2]} - 8'h20;
    // term shown by a mask read: the one last addressed by a mask write
    reg  [7:0]  term_sel;

    always @(posedge aclk) begin : axi_regs
        integer c;
        integer k;
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0000_0000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            term_sel <= 8'h00;
            speed_bit <= 1'b0;
            secure_bit <= 1'b0;
            for (c = 0; c < 16; c = c + 1) begin
                cell_cfg[c] <= `PMOC_CELL_ERASED;
            end
            for (k = 0; k < 160; k = k + 1) begin
                term_mask[k] <= 40'hFF_FFFF_FFFF;
            end
        end else begin
            s_axi_awready <= !aw_held && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_held && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                if (wa == `PMOC_OFS_ERASE && w_data[0]) begin
                    speed_bit <= 1'b0;
                    secure_bit <= 1'b0;
                    for (c = 0; c < 16; c = c + 1) begin
                        cell_cfg[c] <= `PMOC_CELL_ERASED;
                    end
                    for (k = 0; k < 160; k = k + 1) begin
                        term_mask[k] <= 40'hFF_FFFF_FFFF;
                    end
                end else if (wa == `PMOC_OFS_GLOBAL) begin
                    // the security bit can be set but only erase or reset clears it
                    speed_bit <= speed_bit | w_data[`PMOC_F_GLOBAL_SPEED];
                    secure_bit <= secure_bit | w_data[`PMOC_F_GLOBAL_SEC];
                end else if (wa >= `PMOC_OFS_CELL_BASE && wa <= `PMOC_OFS_CELL_LAST) begin
                    cell_cfg[w_cell] <= cell_cfg[w_cell] & w_data[15:0];
                end else if (wa >= `PMOC_OFS_TERM_BASE && wa <= `PMOC_OFS_TERM_LAST) begin
                    // window: term index in w_data[31:24], clear mask of 20 bits per write half
                    term_mask[w_term * 8'd0 + w_data[31:24]] <=
                        term_mask[w_term * 8'd0 + w_data[31:24]] &
                        (w_term[0] ? {w_data[19:0], 20'hF_FFFF} : {20'hF_FFFF, w_data[19:0]});
                    term_sel <= w_data[31:24];
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= 32'h0000_0000;
                if (ra == `PMOC_OFS_GLOBAL) begin
                    s_axi_rdata <= {30'h0000_0000, secure_bit, speed_bit};
                end else if (ra == `PMOC_OFS_STATUS) begin
                    s_axi_rdata <= {15'h0000, standby, cell_reg};
                end else if (ra == `PMOC_OFS_INPUTS) begin
                    s_axi_rdata <= {12'h000, pins_now};
                end else if (ra == `PMOC_OFS_ERASE) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (ra >= `PMOC_OFS_CELL_BASE && ra <= `PMOC_OFS_CELL_LAST) begin
                    if (!secure_bit) begin
                        s_axi_rdata <= {16'h0000, cell_cfg[ra[5:2]]};
                    end
                end else if (ra >= `PMOC_OFS_TERM_BASE && ra <= `PMOC_OFS_TERM_LAST) begin
                    // indices past the last term read as zero
                    if (!secure_bit && term_sel < 8'd160) begin
                        s_axi_rdata <= {12'h000, r_term[0] ? term_mask[term_sel][39:20]
                                                          : term_mask[term_sel][19:0]};
                    end
                end else begin
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pmoc_top
`default_nettype wire

/* File: rtl/pmoc_map.vh */
`ifndef PMOC_MAP_VH
`define PMOC_MAP_VH
// ***********************************************
// register byte offsets
// ***********************************************
`define PMOC_OFS_GLOBAL     12'h000
`define PMOC_OFS_STATUS     12'h004
`define PMOC_OFS_ERASE      12'h008
`define PMOC_OFS_INPUTS     12'h00C
`define PMOC_OFS_CELL_BASE  12'h040
`define PMOC_OFS_CELL_LAST  12'h07C
`define PMOC_OFS_TERM_BASE  12'h080
`define PMOC_OFS_TERM_LAST  12'h0BC
// ***********************************************
// cell configuration fields
// ***********************************************
`define PMOC_F_TYPE_LO      0
`define PMOC_F_TYPE_HI      1
`define PMOC_F_OSEL_LO      2
`define PMOC_F_OSEL_HI      3
`define PMOC_F_FSEL_LO      4
`define PMOC_F_FSEL_HI      5
`define PMOC_F_MODE         6
`define PMOC_F_INV          7
`define PMOC_F_SPLIT_LO     8
`define PMOC_F_SPLIT_HI     15
`define PMOC_F_GLOBAL_SPEED 0
`define PMOC_F_GLOBAL_SEC   1
// erased value: all bits connected
`define PMOC_CELL_ERASED    16'hFFFF
`define PMOC_TERM_ERASED    32'hFFFF_FFFF
// type codes
`define PMOC_TYPE_D         2'h0
`define PMOC_TYPE_T         2'h1
`define PMOC_TYPE_JK        2'h2
`define PMOC_TYPE_SR        2'h3
// output select codes: 1 and 2 drive nothing, the erased code 3 is combinatorial
`define PMOC_OSEL_REG       2'h0
`define PMOC_OSEL_COMB      2'h3
// feedback select codes: 1 and 2 feed nothing back, the erased code 3 is the pin
`define PMOC_FSEL_REG       2'h0
`define PMOC_FSEL_PIN       2'h3
// ***********************************************
// timing
// ***********************************************
`define PMOC_CLK_NS         100
`define PMOC_STANDBY_NS     100
`define PMOC_WAKE_NS        25
`define PMOC_STANDBY_CYC    ((`PMOC_STANDBY_NS / `PMOC_CLK_NS) < 1 ? 1 : (`PMOC_STANDBY_NS / `PMOC_CLK_NS))
`define PMOC_WAKE_CYC       (((`PMOC_WAKE_NS + `PMOC_CLK_NS - 1) / `PMOC_CLK_NS) < 1 ? 1 : \
                             ((`PMOC_WAKE_NS + `PMOC_CLK_NS - 1) / `PMOC_CLK_NS))
`endif

/* File: testbench/pmoc_checker.sv */
`include "pmoc_map.vh"
`default_nettype none
module pmoc_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [3:0]  dedicated_in,
    input wire logic [15:0] io_in,
    input wire logic        standby
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic        speed_on;
    logic        sec_on;
    logic [2:0]  idle_cnt;
    wire         ar_hs   = s_axi_arvalid && s_axi_arready;
    wire         ar_cell = s_axi_araddr[11:0] >= `PMOC_OFS_CELL_BASE && s_axi_araddr[11:0] <= `PMOC_OFS_CELL_LAST;
    wire         ar_bad  = s_axi_araddr[11:0] > `PMOC_OFS_INPUTS && s_axi_araddr[11:0] < `PMOC_OFS_CELL_BASE;
    wire         busy    = s_axi_awvalid || s_axi_wvalid || s_axi_arvalid || s_axi_bvalid || s_axi_rvalid;
    // ***********************************************
    // shadow of the global bits and input quiet time
    // ***********************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_on <= 1'b0;
            sec_on   <= 1'b0;
            idle_cnt <= 3'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr[11:0];
            if (s_axi_wvalid && s_axi_wready) wr_data <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && wr_addr == `PMOC_OFS_GLOBAL) begin
                speed_on <= speed_on | wr_data[`PMOC_F_GLOBAL_SPEED];
                sec_on   <= sec_on | wr_data[`PMOC_F_GLOBAL_SEC];
            end
            if (s_axi_bvalid && s_axi_bready && wr_addr == `PMOC_OFS_ERASE && wr_data[0]) begin
                speed_on <= 1'b0;
                sec_on   <= 1'b0;
            end
            if (busy || !$stable(io_in) || !$stable(dedicated_in)) idle_cnt <= 3'h0;
            else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_SPEED_AWAKE: assert property (speed_on && $past(speed_on, 2) |-> !standby)
        else $error("standby with speed bit set");
    AST_IDLE_SLEEP: assert property (!speed_on && idle_cnt == 3'h4 |-> standby)
        else $error("no standby after quiet inputs");
    AST_WAKE: assert property (standby && !($stable(io_in) && $stable(dedicated_in)) |-> ##[0:2] !standby)
        else $error("input change did not wake");
    AST_SEC_READ: assert property (sec_on && ar_hs && ar_cell |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("config visible while secured");
    AST_BAD_READ: assert property (ar_hs && ar_bad |=> s_axi_rvalid && s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    AST_READ_LAT: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    AST_B_AFTER: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer missing");
    AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    COV_SLEEP: cover property ($rose(standby));
    COV_BAD: cover property (ar_hs && ar_bad);
    COV_SEC: cover property (sec_on && ar_hs && ar_cell);
endmodule // pmoc_checker
bind pmoc_top pmoc_checker i_pmoc_checker (.*);
`default_nettype wire

/* File: testbench/pmoc_board.sv */
`default_nettype none
module pmoc_board (
    input  wire logic [15:0] io_out,
    input  wire logic [15:0] io_oe,
    input  wire logic [15:0] board_level,
    output logic      [15:0] io_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // driven pins read back the device level, the rest follow the board
    assign io_in = (io_oe & io_out) | (~io_oe & board_level);
endmodule // pmoc_board
`default_nettype wire

/* File: testbench/pmoc_top_bench.sv */
`include "pmoc_map.vh"
`default_nettype none
module pmoc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, standby;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0]  dedicated_in = 4'h0;
    logic [15:0] board_level = 16'h0000;
    logic        sync_clock_left_half = 1'b0, sync_clock_right_half = 1'b0;
    logic [15:0] io_in, io_out, io_oe;
    int          error_cnt = 0;
    int          compares = 0;
    always #50 aclk = ~aclk;
    pmoc_top i_pmoc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .dedicated_in(dedicated_in), .sync_clock_left_half(sync_clock_left_half),
        .sync_clock_right_half(sync_clock_right_half), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .standby(standby));
    pmoc_board i_pmoc_board (.io_out(io_out), .io_oe(io_oe), .board_level(board_level), .io_in(io_in));
    // ***********************************************
    // bus cycles and comparison
    // ***********************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ***********************************************
    // tests
    // ***********************************************
    initial begin
        logic [31:0] rd;
        logic [1:0]  rs;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`PMOC_OFS_GLOBAL, rd, rs);
        check(rd, 32'h0000_0000);
        check({io_oe, io_out}, 32'h0000_FFFF);
        for (int c = 0; c < 16; c++) begin
            axi_read(`PMOC_OFS_CELL_BASE + 4 * c, rd, rs);
            check(rd, 32'h0000_FFFF);
        end
        axi_write(`PMOC_OFS_CELL_BASE + 20, 32'h0000_C3A5, rs);
        axi_write(`PMOC_OFS_CELL_BASE + 20, 32'h0000_3CFF, rs);
        axi_read(`PMOC_OFS_CELL_BASE + 20, rd, rs);
        check(rd, 32'h0000_00A5);
        axi_read(32'h0000_0010, rd, rs);
        check(rs, 32'h0000_0002);
        axi_write(32'h0000_00C0, 32'h0000_0001, rs);
        check(rs, 32'h0000_0002);
        axi_write(`PMOC_OFS_GLOBAL, 32'h0000_0002, rs);
        axi_read(`PMOC_OFS_CELL_BASE, rd, rs);
        check(rd, 32'h0000_0000);
        check(rs, 32'h0000_0000);
        axi_write(`PMOC_OFS_ERASE, 32'h0000_0001, rs);
        axi_read(`PMOC_OFS_CELL_BASE + 20, rd, rs);
        check(rd, 32'h0000_FFFF);
        axi_read(`PMOC_OFS_GLOBAL, rd, rs);
        check(rd, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            repeat (6) @(posedge aclk);
            check(standby, 32'h0000_0001);
            if (k == 0) dedicated_in <= ~dedicated_in;
            else board_level <= ~board_level;
            for (int n = 0; n < 4 && standby !== 1'b0; n++) @(posedge aclk);
            check(standby, 32'h0000_0000);
        end
        axi_write(`PMOC_OFS_GLOBAL, 32'h0000_0001, rs);
        axi_read(`PMOC_OFS_GLOBAL, rd, rs);
        check(rd, 32'h0000_0001);
        repeat (10) @(posedge aclk);
        check(standby, 32'h0000_0000);
        // cell 0 sums input 0 combinatorially, cell 8 registers input 1 on the right clock
        axi_write(`PMOC_OFS_TERM_BASE, 32'h0001_0000, rs);
        axi_write(`PMOC_OFS_TERM_BASE + 4, 32'h0000_0000, rs);
        axi_write(`PMOC_OFS_TERM_BASE, 32'h5002_0000, rs);
        axi_write(`PMOC_OFS_TERM_BASE + 4, 32'h5000_0000, rs);
        axi_write(`PMOC_OFS_TERM_BASE, 32'h5900_0000, rs);
        axi_write(`PMOC_OFS_TERM_BASE + 4, 32'h5900_0000, rs);
        axi_write(`PMOC_OFS_CELL_BASE, 32'h0000_FFBF, rs);
        axi_write(`PMOC_OFS_CELL_BASE + 32, 32'h0000_FF40, rs);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) axi_write(`PMOC_OFS_CELL_BASE, 32'h0000_FF3F, rs);
            dedicated_in <= 4'(i);
            sync_clock_left_half <= 1'b1;
            @(posedge aclk);
            sync_clock_left_half <= 1'b0;
            repeat (3) @(posedge aclk);
            check({io_oe[0], io_out[0]}, 32'h0000_0002 | ((i & 1) ^ (i < 2)));
            check({io_oe[8], io_out[8]}, 32'h0000_0002 | (i == 3));
            sync_clock_right_half <= 1'b1;
            @(posedge aclk);
            sync_clock_right_half <= 1'b0;
            repeat (3) @(posedge aclk);
            check({io_oe[8], io_out[8]}, 32'h0000_0002 | (i >> 1));
        end
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        complete_run();
    end
endmodule // pmoc_top_bench
`default_nettype wire
